// ### rtl/elg_pkg.sv
// Shared constants for the encoder latch, gate and frequency block.
// Assumes a single 125 MHz clock and a simple strobe register port.
package elg_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ADDR_W   = 8;   // Register address width
  localparam int DATA_W   = 32;  // Register data width
  localparam int CNT_W    = 32;  // Position counter width
  localparam int PER_W    = 24;  // Period counter width
  localparam int DIVD_W   = 64;  // Dividend width
  localparam int DIVS_W   = 32;  // Divisor and quotient width

  ////////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;  // Control bits
  localparam logic [7:0] OFS_STATUS = 8'h04;  // Status bits
  localparam logic [7:0] OFS_COUNT  = 8'h08;  // Counter value
  localparam logic [7:0] OFS_LATCH1 = 8'h0c;  // First capture value
  localparam logic [7:0] OFS_LATCH2 = 8'h10;  // Second capture value
  localparam logic [7:0] OFS_FREQ   = 8'h14;  // Frequency value
  localparam logic [7:0] OFS_FWIN   = 8'h18;  // Window length in us
  localparam logic [7:0] OFS_FSCALE = 8'h1c;  // Frequency scaling
  localparam logic [7:0] OFS_FWAIT  = 8'h20;  // Wait time in us

  ////////////////////////////////////////////////////////////////////////////////
  // Control field positions
  localparam int CB_L1_POS  = 0;  // Latch on rising latch edge
  localparam int CB_L1_NEG  = 1;  // Latch on falling latch edge
  localparam int CB_L2_POS  = 2;  // Second latch on rising gate edge
  localparam int CB_L2_NEG  = 3;  // Second latch on falling gate edge
  localparam int CB_CONT1   = 4;  // Continuous first latch
  localparam int CB_CONT2   = 5;  // Continuous second latch
  localparam int CB_SWGATE  = 6;  // Software gate
  localparam int CB_GPOL_LO = 8;  // Gate polarity, two bits

  // Status field positions
  localparam int SB_L1_VALID = 0;
  localparam int SB_L2_VALID = 1;
  localparam int SB_MEAS_DONE = 2;
  localparam int SB_SW_VALID = 3;
  localparam int SB_PIN_LVL  = 4;
  localparam int SB_FROZEN   = 5;

  // Gate polarity codes
  localparam logic [1:0] GPOL_OFF = 2'h0;
  localparam logic [1:0] GPOL_POS = 2'h1;
  localparam logic [1:0] GPOL_NEG = 2'h2;

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and timing
  localparam logic [31:0] FWIN_RST_US   = 32'h00002710;  // 10 ms window
  localparam logic [31:0] FSCALE_RST    = 32'h00000064;  // 100 means 0.01 Hz
  localparam logic [31:0] FSCALE_ONE_HZ = 32'h00000001;  // 1 Hz units
  localparam logic [31:0] FWAIT_RST_US  = 32'h00186a00;  // Plain default wait
  localparam int CLK_PERIOD_NS = 8;    // Clock period
  localparam int TICK_NS       = 10;   // Interval timer step
  localparam int TICKS_PER_US  = 1000 / TICK_NS;
  localparam logic [63:0] TICKS_PER_S = 64'(1000000000 / TICK_NS);
  localparam logic [63:0] CENTI_PER_S = 64'h0000000000000064 * TICKS_PER_S;

endpackage : elg_pkg

// ### rtl/elg_div_if.sv
// Carrier between the frequency logic and its divider.
// Assumes both ends share one clock and reset.
`timescale 1ns/100ps
interface elg_div_if;
  import elg_pkg::*;
  logic                start;     // One-cycle request
  logic [DIVD_W-1:0]   dividend;  // Scaled period count
  logic [DIVS_W-1:0]   divisor;   // Interval in ticks
  logic                busy;      // Request would be ignored
  logic                done;      // One-cycle result pulse
  logic [DIVS_W-1:0]   quotient;  // Saturated result

  modport master (output start, dividend, divisor, input busy, done, quotient);
  modport slave  (input start, dividend, divisor, output busy, done, quotient);
endinterface : elg_div_if

// ### rtl/elg_divider.sv
// Sequential restoring divider, one quotient bit per clock.
// Assumes requests arrive only while busy is low; others are ignored.
`timescale 1ns/100ps
module elg_divider
  import elg_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Divide port
  elg_div_if.slave div
);

  logic [DIVD_W-1:0] quo_ff;    // Shifting dividend and quotient
  logic [DIVS_W-1:0] rem_ff;    // Partial remainder
  logic [DIVS_W-1:0] dsr_ff;    // Held divisor
  logic [6:0]        cnt_ff;    // Iteration count
  logic              busy_ff;   // Iterating
  logic              fin_ff;    // Last iteration just done
  logic              done_ff;   // Result pulse
  logic [DIVS_W-1:0] res_ff;    // Result
  logic [DIVS_W:0]   shifted;   // Remainder with next bit
  logic [DIVS_W:0]   trial;     // Remainder minus divisor

  assign shifted = {rem_ff, quo_ff[DIVD_W-1]};
  assign trial   = shifted - {1'b0, dsr_ff};

  ////////////////////////////////////////////////////////////////////////////////
  // Iteration; 64 steps keep the logic small at the cost of latency
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      quo_ff  <= '0;
      rem_ff  <= '0;
      dsr_ff  <= '0;
      cnt_ff  <= '0;
      busy_ff <= 1'b0;
      fin_ff  <= 1'b0;
    end else if (div.start && !div.busy) begin
      quo_ff  <= div.dividend;
      rem_ff  <= '0;
      dsr_ff  <= div.divisor;
      cnt_ff  <= '0;
      busy_ff <= 1'b1;
      fin_ff  <= 1'b0;
    end else if (busy_ff) begin
      // Subtract when the divisor fits
      if (shifted >= {1'b0, dsr_ff}) begin
        rem_ff <= trial[DIVS_W-1:0];
        quo_ff <= {quo_ff[DIVD_W-2:0], 1'b1};
      end else begin
        rem_ff <= shifted[DIVS_W-1:0];
        quo_ff <= {quo_ff[DIVD_W-2:0], 1'b0};
      end
      cnt_ff  <= cnt_ff + 7'h01;
      busy_ff <= (cnt_ff != 7'h3f);
      fin_ff  <= (cnt_ff == 7'h3f);
    end else begin
      fin_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Result register; a quotient too wide for the port saturates
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      res_ff  <= '0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= fin_ff;
      if (fin_ff) begin
        res_ff <= (|quo_ff[DIVD_W-1:DIVS_W]) ? '1 : quo_ff[DIVS_W-1:0];
      end
    end
  end

  assign div.busy     = busy_ff | fin_ff;
  assign div.done     = done_ff;
  assign div.quotient = res_ff;

endmodule : elg_divider

// ### rtl/elg_encoder_top.sv
// Counter, latch, gate and frequency logic for one encoder channel.
// Assumes encoder and sensor inputs are synchronous levels to ref_clk.
`timescale 1ns/100ps

// Function
// - Rising latch edge captures counter, sets valid
// - Falling gate edge captures second value
// - Both valid flags mark measurement done
// - No rearm until all four enables cleared
// - Gate freezes counter while pin at active level
// - Polarity: off, freeze high, freeze low
// - Gate pin level shown in status
// - Positive gate: capture, then freeze
// - Negative gate: capture, then freeze
// - Software gate freezes, reports valid bit
// - Frequency equals periods over interval
// - Period count starts at first rise
// - Timer rise to last fall, 10 ns
// - Scaling default 0.01 Hz, one gives 1 Hz
// - Frequency runs free of cyclic timing
// - Freeze and resets leave frequency alone
// - Empty window: extend, hold last value
// - Wait expired: discard, output zero
// - One-shot latch holds until enable cleared
// - Continuous latch rewrites on every edge
module elg_encoder_top
  import elg_pkg::*;
(
  // Clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst,
  // Encoder and sensor pins
  input  wire logic              encA,
  input  wire logic              encB,
  input  wire logic              latchIn,
  input  wire logic              gateIn,
  // Register port
  input  wire logic [ADDR_W-1:0] regAddr,
  input  wire logic [DATA_W-1:0] regWdata,
  input  wire logic              regWr,
  input  wire logic              regRd,
  output logic      [DATA_W-1:0] regRdata
);

  ////////////////////////////////////////////////////////////////////////////////
  // Declarations
  logic [3:0]        sync1_ff;     // First synchroniser stage
  logic [3:0]        sync2_ff;     // Settled levels
  logic [3:0]        prev_ff;      // Levels one cycle older
  logic [3:0]        rise;         // Rising edge pulses
  logic [3:0]        fall;         // Falling edge pulses
  logic [DATA_W-1:0] ctrl_ff;      // Control register
  logic [31:0]       fwin_ff;      // Window length in us
  logic [31:0]       fscale_ff;    // Frequency scaling
  logic [31:0]       fwait_ff;     // Wait time in us
  logic [CNT_W-1:0]  count_ff;     // Position counter
  logic [CNT_W-1:0]  latch1_ff;    // First capture
  logic [CNT_W-1:0]  latch2_ff;    // Second capture
  logic              valid1_ff;    // First capture valid
  logic              valid2_ff;    // Second capture valid
  logic [DATA_W-1:0] rdata_ff;     // Read data
  logic [1:0]        gatePol;      // Gate polarity field
  logic              pinLvl;       // Gate pin level, freeze_pin_level
  logic              gateFreeze;   // Gate pin holds the counter
  logic              frozen;       // Counter held by any gate
  logic              allEnOff;     // Every latch enable cleared
  logic              cap1;         // First capture this cycle
  logic              cap2;         // Second capture this cycle
  logic [DATA_W-1:0] statusWord;   // Status register view

  // Frequency measurement
  logic [2:0]        tickAcc_ff;   // Phase of the 10 ns divider, modulo 5
  logic              tick;         // One 10 ns step
  logic [39:0]       winCnt_ff;    // Ticks in current window
  logic [39:0]       waitCnt_ff;   // Ticks since attempt began
  logic              started_ff;   // First rise seen
  logic [31:0]       runTime_ff;   // Ticks since first rise
  logic [31:0]       lastFall_ff;  // Time at last falling edge
  logic [PER_W-1:0]  periods_ff;   // Complete periods
  logic              winEnd;       // Window closes this cycle
  logic              expire;       // Wait time used up
  logic              haveResult;   // Window holds a full period
  logic [39:0]       winLimit;     // Window in ticks
  logic [39:0]       waitLimit;    // Wait in ticks
  logic [63:0]       scaleFactor;  // Ticks per second times scaling
  logic              divStart_ff;  // Divide request
  logic [DIVD_W-1:0] dividend_ff;  // Scaled periods
  logic [DIVS_W-1:0] divisor_ff;   // Interval
  logic [DIVS_W-1:0] freq_ff;      // Published frequency

  elg_div_if divBus ();

  ////////////////////////////////////////////////////////////////////////////////
  // Synchronisers and edge detectors, one per input pin
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_sync
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          sync1_ff[gi] <= 1'b0;
          sync2_ff[gi] <= 1'b0;
          prev_ff[gi]  <= 1'b0;
        end else begin
          sync1_ff[gi] <= (gi == 0) ? encA : (gi == 1) ? encB : (gi == 2) ? latchIn : gateIn;
          sync2_ff[gi] <= sync1_ff[gi];
          prev_ff[gi]  <= sync2_ff[gi];
        end
      end
      assign rise[gi] = sync2_ff[gi] & ~prev_ff[gi];
      assign fall[gi] = ~sync2_ff[gi] & prev_ff[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Gate decoding
  assign gatePol    = ctrl_ff[CB_GPOL_LO+1:CB_GPOL_LO];
  assign pinLvl     = sync2_ff[3];
  // Level-based freeze: the counter is held only while the gate pin is at the active level
  assign gateFreeze = ((gatePol == GPOL_POS) && pinLvl) ||
                      ((gatePol == GPOL_NEG) && !pinLvl);
  assign frozen     = gateFreeze | ctrl_ff[CB_SWGATE];
  assign allEnOff   = ~|{ctrl_ff[CB_L1_POS], ctrl_ff[CB_L1_NEG],
                         ctrl_ff[CB_L2_POS], ctrl_ff[CB_L2_NEG]};

  ////////////////////////////////////////////////////////////////////////////////
  // Position counter, one count per track A rise, direction from track B
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      count_ff <= '0;
    end else if (rise[0] && !frozen) begin
      count_ff <= sync2_ff[1] ? count_ff - 1'b1 : count_ff + 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Captures; the capture takes the count of the edge cycle, so a gate
  // that freezes on the same edge still sees the value stored first
  assign cap1 = ((rise[2] && ctrl_ff[CB_L1_POS]) || (fall[2] && ctrl_ff[CB_L1_NEG])) &&
                (!valid1_ff || ctrl_ff[CB_CONT1]);
  assign cap2 = ((rise[3] && ctrl_ff[CB_L2_POS]) || (fall[3] && ctrl_ff[CB_L2_NEG])) &&
                (!valid2_ff || ctrl_ff[CB_CONT2]);

  // First capture; valid clears only once every enable is off
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch1_ff <= '0;
      valid1_ff <= 1'b0;
    end else if (cap1) begin
      latch1_ff <= count_ff;
      valid1_ff <= 1'b1;
    end else if (allEnOff) begin
      valid1_ff <= 1'b0;
    end
  end

  // Second capture
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      latch2_ff <= '0;
      valid2_ff <= 1'b0;
    end else if (cap2) begin
      latch2_ff <= count_ff;
      valid2_ff <= 1'b1;
    end else if (allEnOff) begin
      valid2_ff <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Register writes
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ctrl_ff   <= '0;
      fwin_ff   <= FWIN_RST_US;
      fscale_ff <= FSCALE_RST;
      fwait_ff  <= FWAIT_RST_US;
    end else if (regWr) begin
      case (regAddr)
        OFS_CTRL:   ctrl_ff   <= regWdata & 32'h0000037f;
        OFS_FWIN:   fwin_ff   <= regWdata;
        OFS_FSCALE: fscale_ff <= regWdata;
        OFS_FWAIT:  fwait_ff  <= regWdata;
        default:    ;  // Unmapped and read-only: ignored
      endcase
    end
  end

  // Status view
  always_comb begin
    statusWord               = '0;
    statusWord[SB_L1_VALID]  = valid1_ff;
    statusWord[SB_L2_VALID]  = valid2_ff;
    statusWord[SB_MEAS_DONE] = valid1_ff & valid2_ff;
    statusWord[SB_SW_VALID]  = ctrl_ff[CB_SWGATE];
    statusWord[SB_PIN_LVL]   = pinLvl;
    statusWord[SB_FROZEN]    = frozen;
  end

  // Read data, valid the cycle after the strobe only
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (regRd) begin
      case (regAddr)
        OFS_CTRL:   rdata_ff <= ctrl_ff;
        OFS_STATUS: rdata_ff <= statusWord;
        OFS_COUNT:  rdata_ff <= count_ff;
        OFS_LATCH1: rdata_ff <= latch1_ff;
        OFS_LATCH2: rdata_ff <= latch2_ff;
        OFS_FREQ:   rdata_ff <= freq_ff;
        OFS_FWIN:   rdata_ff <= fwin_ff;
        OFS_FSCALE: rdata_ff <= fscale_ff;
        OFS_FWAIT:  rdata_ff <= fwait_ff;
        default:    rdata_ff <= '0;  // Unmapped reads zero
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end
  assign regRdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////////////
  // 10 ns step from the 8 ns clock: phase counter modulo 5, step on four phases.
  // Steps jitter by one clock, but average exactly 10 ns.
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tickAcc_ff <= '0;
    end else begin
      tickAcc_ff <= (tickAcc_ff == 3'h4) ? 3'h0 : tickAcc_ff + 3'h1;
    end
  end
  // Four steps in every five clocks is 8/10
  assign tick = (tickAcc_ff != 3'h4);

  ////////////////////////////////////////////////////////////////////////////////
  // Frequency window; driven only by track A and free-running timers, never by
  // the gate, the counter or any cyclic exchange
  assign winLimit    = {8'h00, fwin_ff} * 40'd100;
  assign waitLimit   = {8'h00, fwait_ff} * 40'd100;
  assign winEnd      = tick && (winCnt_ff + 40'h1 >= winLimit);
  assign haveResult  = (periods_ff != '0) && (lastFall_ff != '0);
  assign expire      = winEnd && !haveResult && (waitCnt_ff + 40'h1 >= waitLimit);
  assign scaleFactor = (fscale_ff == FSCALE_ONE_HZ) ? TICKS_PER_S : CENTI_PER_S;

  // Window and wait timers
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      winCnt_ff  <= '0;
      waitCnt_ff <= '0;
    end else begin
      if (winEnd) begin
        winCnt_ff <= '0;
      end else if (tick) begin
        winCnt_ff <= winCnt_ff + 40'h1;
      end
      // The wait keeps running across empty windows
      if (winEnd && (haveResult || expire)) begin
        waitCnt_ff <= '0;
      end else if (tick) begin
        waitCnt_ff <= waitCnt_ff + 40'h1;
      end
    end
  end

  // Period count and interval timer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      started_ff  <= 1'b0;
      runTime_ff  <= '0;
      lastFall_ff <= '0;
      periods_ff  <= '0;
    end else if (winEnd && (haveResult || expire)) begin
      // A rise in the closing cycle opens the next measurement
      started_ff  <= rise[0];
      runTime_ff  <= '0;
      lastFall_ff <= '0;
      periods_ff  <= '0;
    end else begin
      if (rise[0] && !started_ff) begin
        started_ff <= 1'b1;
        runTime_ff <= '0;
      end else if (started_ff) begin
        if (tick) begin
          runTime_ff <= runTime_ff + 32'h1;
        end
        if (rise[0]) begin
          periods_ff <= periods_ff + 1'b1;
        end
        if (fall[0]) begin
          lastFall_ff <= runTime_ff;
        end
      end
    end
  end

  // Divide request; a window closing while the divider still works is skipped
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      divStart_ff <= 1'b0;
      dividend_ff <= '0;
      divisor_ff  <= '0;
    end else begin
      divStart_ff <= winEnd && haveResult && !divBus.busy;
      if (winEnd && haveResult) begin
        dividend_ff <= 64'({40'h0, periods_ff} * scaleFactor);
        divisor_ff  <= lastFall_ff;
      end
    end
  end
  assign divBus.start    = divStart_ff;
  assign divBus.dividend = dividend_ff;
  assign divBus.divisor  = divisor_ff;

  // Published frequency; holds through empty windows
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      freq_ff <= '0;
    end else if (expire) begin
      freq_ff <= '0;
    end else if (divBus.done) begin
      freq_ff <= divBus.quotient;
    end
  end

  elg_divider u_div (
    .ref_clk (ref_clk),
    .rst     (rst),
    .div     (divBus)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence seqGateRiseCap;
    (gatePol == GPOL_POS) && ctrl_ff[CB_L2_POS] && rise[3] && !valid2_ff;
  endsequence
  sequence seqStoredThenHeld;
    (latch2_ff == $past(count_ff)) ##1 (count_ff == $past(count_ff));
  endsequence

  AST_L1_CAPTURE: assert property (@(posedge ref_clk) disable iff (rst)
    (rise[2] && ctrl_ff[CB_L1_POS] && !valid1_ff) |=>
      (valid1_ff && latch1_ff == $past(count_ff)))
    else $error("first capture missed");
  AST_L2_CAPTURE: assert property (@(posedge ref_clk) disable iff (rst)
    (fall[3] && ctrl_ff[CB_L2_NEG] && !valid2_ff) |=>
      (valid2_ff && latch2_ff == $past(count_ff)))
    else $error("second capture missed");
  AST_DONE_FLAG: assert property (@(posedge ref_clk) disable iff (rst)
    (regRd && regAddr == OFS_STATUS && valid1_ff && valid2_ff) |=> regRdata[SB_MEAS_DONE])
    else $error("done flag wrong");
  AST_NO_REARM: assert property (@(posedge ref_clk) disable iff (rst)
    (valid1_ff && !ctrl_ff[CB_CONT1] && !allEnOff) |=>
      (valid1_ff && $stable(latch1_ff)))
    else $error("capture rearmed early");
  AST_FROZEN_HOLD: assert property (@(posedge ref_clk) disable iff (rst)
    frozen |=> $stable(count_ff))
    else $error("frozen counter moved");
  AST_PIN_LEVEL: assert property (@(posedge ref_clk) disable iff (rst)
    (!$past(rst, 1) && !$past(rst, 2) && !$past(rst, 3)) |->
      (statusWord[SB_PIN_LVL] == $past(gateIn, 2)))
    else $error("pin level stale");
  AST_POS_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    seqGateRiseCap |=> seqStoredThenHeld)
    else $error("capture before freeze broken");
  AST_SW_GATE: assert property (@(posedge ref_clk) disable iff (rst)
    ctrl_ff[CB_SWGATE] |-> (frozen && statusWord[SB_SW_VALID]) ##1 $stable(count_ff))
    else $error("software gate not applied");
  AST_FREQ_ZERO: assert property (@(posedge ref_clk) disable iff (rst)
    expire |=> (freq_ff == '0))
    else $error("frequency not cleared");
  AST_FREQ_PUBLISH: assert property (@(posedge ref_clk) disable iff (rst)
    (divBus.done && !expire) |=> (freq_ff == $past(divBus.quotient)))
    else $error("frequency not published");
  AST_CONT_LATCH: assert property (@(posedge ref_clk) disable iff (rst)
    (ctrl_ff[CB_CONT1] && ctrl_ff[CB_L1_POS] && rise[2]) |=>
      (latch1_ff == $past(count_ff)))
    else $error("continuous capture missed");

endmodule : elg_encoder_top

// ### verification/elg_pins_model.sv
// Encoder and sensor model: track A square wave while run is high, B low.
// Assumes the bench sets run and sensor levels; pins move after the edge.
`timescale 1ns/100ps
module elg_pins_model #(parameter int HALF = 20) (
  // Clock and bench controls
  input  wire logic ref_clk,
  input  wire logic run,
  input  wire logic latchCmd,
  input  wire logic gateCmd,
  // Pins
  output logic      encA,
  output logic      encB,
  output logic      latchIn,
  output logic      gateIn
);
  int half = 0;  // Clocks into this half period
  initial {encA, encB, latchIn, gateIn} = 4'h0;
  ////////////////////////////////////////////////////////////////////////////////
  // Sensors follow the bench; B stays low so the count only rises
  always @(posedge ref_clk) begin
    latchIn <= latchCmd;
    gateIn  <= gateCmd;
    // A halted shaft leaves A at its last level
    if (run) begin
      half <= (half == HALF - 1) ? 0 : half + 1;
      if (half == HALF - 1) encA <= ~encA;
    end
  end
endmodule : elg_pins_model

// ### verification/tb_elg_encoder_top.sv
// Bench for the encoder latch, gate and frequency block.
// Assumes the strobe register port and the pin model beside the design.
`timescale 1ns/100ps
module tb_elg_encoder_top;
  import elg_pkg::*;
  logic ref_clk = 0, rst = 1, regWr = 0, regRd = 0, run = 0, latchCmd = 0, gateCmd = 0;
  logic encA, encB, latchIn, gateIn;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWdata = '0, regRdata, v, c;
  int mismatches = 0, compares = 0, cyc = 0;
  always #4 ref_clk = ~ref_clk;
  elg_pins_model i_elg_pins_model (.ref_clk, .run, .latchCmd, .gateCmd, .encA, .encB,
    .latchIn, .gateIn);
  elg_encoder_top i_elg_encoder_top (.ref_clk, .rst, .encA, .encB, .latchIn, .gateIn,
    .regAddr, .regWdata, .regWr, .regRd, .regRdata);
  ////////////////////////////////////////////////////////////////////////////////
  // Bus cycles, waits and the range compare
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge ref_clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge ref_clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge ref_clk);
    regRd <= 1'b0;
    #1 v = regRdata;
  endtask : rd
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wt
  task automatic chk(input string n, input logic [31:0] g, lo, hi);
    compares++;
    // An unknown value never lands inside the range
    if ((g >= lo && g <= hi) !== 1'b1) begin
      mismatches++;
      $display("MISMATCH %s expected %h..%h seen %h", n, lo, hi, g);
    end
  endtask : chk
  task automatic summarize;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : summarize
  // Hang guard, well above the roughly 6800 cycles the run takes
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      mismatches++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    wt(5);
    rst <= 1'b0;
    rd(OFS_FWIN);
    chk("fwin", v, FWIN_RST_US, FWIN_RST_US);
    rd(OFS_FSCALE);
    chk("fscale", v, FSCALE_RST, FSCALE_RST);
    wr(OFS_FWIN, 32'h2);
    wr(OFS_FSCALE, FSCALE_ONE_HZ);
    run <= 1'b1;
    wt(1000);
    rd(OFS_FREQ);
    chk("freqHz", v, 32'h2625a0, 32'h3567e0);
    wr(OFS_FSCALE, FSCALE_RST);
    wt(1000);
    wr(OFS_CTRL, 32'h40);
    wt(1000);
    rd(OFS_FREQ);
    chk("freqCenti", v, 32'h0ee6b280, 32'h14dc9380);
    rd(OFS_STATUS);
    chk("swGate", {v[5], v[3]}, 3, 3);
    rd(OFS_COUNT);
    c = v;
    wr(OFS_CTRL, 32'h41);
    latchCmd <= 1'b1;
    wt(8);
    rd(OFS_COUNT);
    chk("frozen", v, c, c);
    rd(OFS_STATUS);
    chk("valid1", v[0], 1, 1);
    rd(OFS_LATCH1);
    chk("cap1", v, c, c);
    wr(OFS_CTRL, 32'h09);
    latchCmd <= 1'b0;
    wt(100);
    latchCmd <= 1'b1;
    wt(8);
    rd(OFS_LATCH1);
    chk("cap1Held", v, c, c);
    wr(OFS_CTRL, 32'h49);
    rd(OFS_COUNT);
    c = v;
    gateCmd <= 1'b1;
    wt(8);
    rd(OFS_STATUS);
    chk("pinHigh", v[4], 1, 1);
    gateCmd <= 1'b0;
    wt(8);
    rd(OFS_STATUS);
    chk("both", v[4:0], 5'h0f, 5'h0f);
    rd(OFS_LATCH2);
    chk("cap2", v, c, c);
    wr(OFS_CTRL, 32'h48);
    rd(OFS_STATUS);
    chk("noRearm", v[1:0], 3, 3);
    wr(OFS_CTRL, 32'h40);
    rd(OFS_STATUS);
    chk("rearm", v[1:0], 0, 0);
    wr(OFS_FWAIT, 32'ha);
    run <= 1'b0;
    // The window cut by the stop may still publish a short-run value; settled by then
    wt(400);
    rd(OFS_FREQ);
    c = v;
    chk("freqLast", c, 32'h0bebc200, 32'h2faf0800);
    wt(400);
    rd(OFS_FREQ);
    chk("freqHold", v, c, c);
    wt(2600);
    rd(OFS_FREQ);
    chk("freqZero", v, 0, 0);
    wr(OFS_CTRL, 32'h104);
    rd(OFS_COUNT);
    c = v;
    gateCmd <= 1'b1;
    wt(8);
    rd(OFS_STATUS);
    chk("posGate", {v[5], v[1]}, 3, 3);
    rd(OFS_LATCH2);
    chk("cap2Pos", v, c, c);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h208);
    gateCmd <= 1'b0;
    wt(8);
    rd(OFS_STATUS);
    chk("negGate", {v[5], v[1]}, 3, 3);
    // Continuous capture: a second edge must overwrite the first, older count
    wr(OFS_CTRL, 32'h11);
    latchCmd <= 1'b0;
    run      <= 1'b1;
    wt(8);
    latchCmd <= 1'b1;
    wt(100);
    wr(OFS_CTRL, 32'h51);
    rd(OFS_COUNT);
    c = v;
    latchCmd <= 1'b0;
    wt(8);
    latchCmd <= 1'b1;
    wt(8);
    rd(OFS_LATCH1);
    chk("cap1Cont", v, c, c);
    summarize();
  end
endmodule : tb_elg_encoder_top
